//--- kpi_pkg.sv
package kpi_pkg;
   localparam int KPI_PINS = 7;
   localparam logic [11:0] KPI_OFF_STATUS_CONTROL = 12'h000;
   localparam logic [11:0] KPI_OFF_PIN_ENABLE = 12'h004;
   localparam logic [11:0] KPI_OFF_BREAK_FLAG_CONTROL = 12'h008;
   localparam logic [11:0] KPI_OFF_IRQ_STATUS = 12'h00C;
   localparam logic [11:0] KPI_OFF_IRQ_MASK = 12'h010;
   localparam logic [11:0] KPI_OFF_PIN_LEVEL = 12'h014;
   localparam int KPI_BIT_MODE = 0;
   localparam int KPI_BIT_MASK = 1;
   localparam int KPI_BIT_ACK = 2;
   localparam int KPI_BIT_FLAG = 3;
   localparam int KPI_BIT_PERMIT = 0;
   localparam int KPI_EV_KEY = 0;
   localparam int KPI_EV_WAKE = 1;
   localparam int KPI_EV_COUNT = 2;
   localparam logic [1:0] KPI_EV_RESET = 2'h0;
   localparam logic [6:0] KPI_PIN_RESET = 7'h7F;
endpackage

//--- kpi_sync.sv
`timescale 1ns/1ns
// Three-stage pin synchroniser; change counts when stages two and three agree
module kpi_sync #(
   parameter int WIDTH = 7
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [WIDTH-1:0] pin_async,
   output logic [WIDTH-1:0] pin_sync
);
   logic [WIDTH-1:0] s1_ff;
   logic [WIDTH-1:0] s2_ff;
   logic [WIDTH-1:0] s3_ff;

   initial begin
      if (WIDTH < 1 || WIDTH > 8) $error("kpi_sync width out of range");
   end

   // Shift chain, idle high for pulled-up keys
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_ff <= '1;
         s2_ff <= '1;
         s3_ff <= '1;
         pin_sync <= '1;
      end else begin
         s1_ff <= pin_async;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         for (int i = 0; i < WIDTH; i++) begin
            if (s2_ff[i] == s3_ff[i]) begin
               pin_sync[i] <= s3_ff[i];
            end
         end
      end
   end
endmodule

//--- kpi_apb.sv
`timescale 1ns/1ns
// APB slave front end: zero wait states, error on unmapped address
module kpi_apb (
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic mapped,
   output logic pready,
   output logic pslverr,
   output logic wr_en,
   output logic rd_en
);
   // Access phase decode
   always_comb begin
      pready = 1'b1;
      pslverr = psel && penable && !mapped;
      wr_en = psel && penable && pwrite && mapped;
      rd_en = psel && penable && !pwrite && mapped;
   end
endmodule

//--- kpi_top.sv
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/1ns
// Keypad interrupt unit with APB registers
module kpi_top #(
   parameter int PINS = kpi_pkg::KPI_PINS
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [PINS-1:0] keypad_input_pins,
   input wire logic break_state,
   input wire logic low_power_mode,
   output logic keypad_irq,
   output logic wake_request,
   output logic irq
);
   import kpi_pkg::*;

   initial begin
      if (PINS < 1 || PINS > 8) $error("kpi_top pin count out of range");
   end

   logic [PINS-1:0] pins_s;
   logic [PINS-1:0] pins_d_ff;
   logic [PINS-1:0] keypad_pin_enable_ff;
   logic mode_ff;
   logic keypad_irq_mask_ff;
   logic latch_ff;
   logic break_clear_permit_ff;
   logic [1:0] ev_status_ff;
   logic [1:0] ev_mask_ff;
   logic wr_en;
   logic rd_en;
   logic mapped;
   logic [PINS-1:0] falls;
   logic level_req;
   logic set_req;
   logic ack_wr;
   logic ack_ok;
   logic [1:0] ev_set;
   logic setup_rd;
   logic cfg_wr;
   logic sel_status;
   logic sel_enable;
   logic sel_permit;
   logic sel_ev_status;
   logic sel_ev_mask;
   logic sel_level;

   kpi_sync #(.WIDTH(PINS)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .pin_async(keypad_input_pins),
      .pin_sync(pins_s)
   );

   kpi_apb u_apb (
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .mapped(mapped),
      .pready(pready),
      .pslverr(pslverr),
      .wr_en(wr_en),
      .rd_en(rd_en)
   );

   // Address decode, one select per register
   always_comb begin
      sel_status = 1'b0;
      sel_enable = 1'b0;
      sel_permit = 1'b0;
      sel_ev_status = 1'b0;
      sel_ev_mask = 1'b0;
      sel_level = 1'b0;
      case (paddr)
         KPI_OFF_STATUS_CONTROL: sel_status = 1'b1;
         KPI_OFF_PIN_ENABLE: sel_enable = 1'b1;
         KPI_OFF_BREAK_FLAG_CONTROL: sel_permit = 1'b1;
         KPI_OFF_IRQ_STATUS: sel_ev_status = 1'b1;
         KPI_OFF_IRQ_MASK: sel_ev_mask = 1'b1;
         KPI_OFF_PIN_LEVEL: sel_level = 1'b1;
         default: sel_status = 1'b0;
      endcase
      mapped = sel_status || sel_enable || sel_permit || sel_ev_status || sel_ev_mask || sel_level;
   end

   // Bus phase qualifiers for the checks
   always_comb begin
      cfg_wr = wr_en && pstrb[0];
      setup_rd = psel && !penable && !pwrite;
   end

   // Previous pin level for edge detection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pins_d_ff <= '1;
      end else begin
         pins_d_ff <= pins_s;
      end
   end

   // Request detection: falling edge, or low level in level mode
   always_comb begin
      falls = pins_d_ff & ~pins_s & keypad_pin_enable_ff;
      level_req = mode_ff && |(~pins_s & keypad_pin_enable_ff);
      set_req = |falls || level_req;
      ack_wr = wr_en && (paddr == KPI_OFF_STATUS_CONTROL) && pstrb[0] && pwdata[KPI_BIT_ACK];
      ack_ok = ack_wr && (!break_state || break_clear_permit_ff);
   end

   // Configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_ff <= 1'b0;
         keypad_irq_mask_ff <= 1'b0;
         keypad_pin_enable_ff <= '0;
         break_clear_permit_ff <= 1'b0;
         ev_mask_ff <= KPI_EV_RESET;
      end else if (wr_en && pstrb[0]) begin
         if (paddr == KPI_OFF_STATUS_CONTROL) begin
            mode_ff <= pwdata[KPI_BIT_MODE];
            keypad_irq_mask_ff <= pwdata[KPI_BIT_MASK];
         end
         if (paddr == KPI_OFF_PIN_ENABLE) begin
            keypad_pin_enable_ff <= pwdata[PINS-1:0];
         end
         if (paddr == KPI_OFF_BREAK_FLAG_CONTROL) begin
            break_clear_permit_ff <= pwdata[KPI_BIT_PERMIT];
         end
         if (paddr == KPI_OFF_IRQ_MASK) begin
            ev_mask_ff <= pwdata[1:0];
         end
      end
   end

   // Keyboard latch; a new request wins over acknowledge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         latch_ff <= 1'b0;
      end else if (set_req) begin
         latch_ff <= 1'b1;
      end else if (ack_ok) begin
         latch_ff <= 1'b0;
      end
   end

   // Request output active in all modes; wake output only in low power mode
   always_comb begin
      keypad_irq = latch_ff && !keypad_irq_mask_ff;
      wake_request = keypad_irq && low_power_mode;
      ev_set = {wake_request, set_req};
      irq = |(ev_status_ff & ev_mask_ff);
   end

   // Sticky event status, write one to clear, set wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ev_status_ff <= KPI_EV_RESET;
      end else begin
         for (int i = 0; i < KPI_EV_COUNT; i++) begin
            if (ev_set[i]) begin
               ev_status_ff[i] <= 1'b1;
            end else if (wr_en && pstrb[0] && paddr == KPI_OFF_IRQ_STATUS && pwdata[i]) begin
               ev_status_ff[i] <= 1'b0;
            end
         end
      end
   end

   // Read data register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (psel && !penable && !pwrite) begin
         prdata <= '0;
         case (paddr)
            KPI_OFF_STATUS_CONTROL: begin
               prdata[KPI_BIT_FLAG] <= latch_ff;
               prdata[KPI_BIT_MASK] <= keypad_irq_mask_ff;
               prdata[KPI_BIT_MODE] <= mode_ff;
               prdata[KPI_BIT_ACK] <= 1'b0;
            end
            KPI_OFF_PIN_ENABLE: prdata[PINS-1:0] <= keypad_pin_enable_ff;
            KPI_OFF_BREAK_FLAG_CONTROL: prdata[KPI_BIT_PERMIT] <= break_clear_permit_ff;
            KPI_OFF_IRQ_STATUS: prdata[1:0] <= ev_status_ff;
            KPI_OFF_IRQ_MASK: prdata[1:0] <= ev_mask_ff;
            KPI_OFF_PIN_LEVEL: prdata[PINS-1:0] <= pins_s;
            default: prdata <= '0;
         endcase
      end
   end

   // Latch set on a falling edge of an enabled pin
   a_edge_sets_latch: assert property (@(posedge pclk) disable iff (!presetn)
      |falls |=> latch_ff)
      else $error("edge did not set latch");
   // Protected latch survives acknowledge in break
   a_break_protect: assert property (@(posedge pclk) disable iff (!presetn)
      latch_ff && ack_wr && break_state && !break_clear_permit_ff |=> latch_ff)
      else $error("latch cleared in protected break");
   // Permitted acknowledge in break clears
   a_break_clear: assert property (@(posedge pclk) disable iff (!presetn)
      ack_wr && break_state && break_clear_permit_ff && !set_req |=> !latch_ff)
      else $error("permitted break clear failed");
   // Normal acknowledge clears
   a_ack_clears: assert property (@(posedge pclk) disable iff (!presetn)
      ack_wr && !break_state && !set_req |=> !latch_ff)
      else $error("acknowledge did not clear");
   // Cleared latch stays clear without new request
   a_stays_clear: assert property (@(posedge pclk) disable iff (!presetn)
      !latch_ff && !set_req |=> !latch_ff)
      else $error("latch set spontaneously");
   // Unmasked latch wakes from low power
   a_wake_out: assert property (@(posedge pclk) disable iff (!presetn)
      latch_ff && !keypad_irq_mask_ff && low_power_mode |-> wake_request)
      else $error("no wake request");
   // Masked latch never wakes
   a_mask_blocks: assert property (@(posedge pclk) disable iff (!presetn)
      keypad_irq_mask_ff |-> !keypad_irq && !wake_request)
      else $error("mask ignored");
   // Status reads: upper nibble and ack read zero
   a_read_zero: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable && !pwrite && paddr == KPI_OFF_STATUS_CONTROL |=> prdata[7:4] == 4'h0 && !prdata[2])
      else $error("status reserved bits nonzero");
   // Flag read reflects latch
   a_flag_read: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable && !pwrite && paddr == KPI_OFF_STATUS_CONTROL |=> prdata[3] == $past(latch_ff))
      else $error("flag read mismatch");
   // Level mode keeps latch set while pin low
   a_level_mode: assert property (@(posedge pclk) disable iff (!presetn)
      level_req |=> latch_ff)
      else $error("level request lost");
   // Access phase always answered at once
   a_ready_access: assert property (@(posedge pclk) disable iff (!presetn)
      psel && penable |-> pready)
      else $error("access not answered");
   // Unmapped access flagged as error
   a_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
      psel && penable && !mapped |-> pslverr)
      else $error("unmapped access not refused");
   // No error outside unmapped access
   a_err_mapped: assert property (@(posedge pclk) disable iff (!presetn)
      !(psel && penable && !mapped) |-> !pslverr)
      else $error("spurious bus error");
   // Refused write never reaches registers
   a_refused_write: assert property (@(posedge pclk) disable iff (!presetn)
      psel && penable && pwrite && !mapped |-> !wr_en)
      else $error("unmapped write accepted");
   // Mode bit takes written value
   a_mode_write: assert property (@(posedge pclk) disable iff (!presetn)
      cfg_wr && sel_status |=> mode_ff == $past(pwdata[KPI_BIT_MODE]))
      else $error("mode write lost");
   // Mask bit takes written value
   a_mask_write: assert property (@(posedge pclk) disable iff (!presetn)
      cfg_wr && sel_status |=> keypad_irq_mask_ff == $past(pwdata[KPI_BIT_MASK]))
      else $error("mask write lost");
   // Pin enables take written value
   a_enable_write: assert property (@(posedge pclk) disable iff (!presetn)
      cfg_wr && sel_enable |=> keypad_pin_enable_ff == $past(pwdata[PINS-1:0]))
      else $error("pin enable write lost");
   // Break clear permit takes written value
   a_permit_write: assert property (@(posedge pclk) disable iff (!presetn)
      cfg_wr && sel_permit |=> break_clear_permit_ff == $past(pwdata[KPI_BIT_PERMIT]))
      else $error("permit write lost");
   // Event mask takes written value
   a_ev_mask_write: assert property (@(posedge pclk) disable iff (!presetn)
      cfg_wr && sel_ev_mask |=> ev_mask_ff == $past(pwdata[KPI_EV_COUNT-1:0]))
      else $error("event mask write lost");
   // Configuration holds without a strobed write
   a_cfg_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !cfg_wr |=> $stable(mode_ff) && $stable(keypad_irq_mask_ff) && $stable(keypad_pin_enable_ff)
         && $stable(break_clear_permit_ff) && $stable(ev_mask_ff))
      else $error("configuration changed without write");
   // Disabled pins raise no request
   a_disabled_quiet: assert property (@(posedge pclk) disable iff (!presetn)
      keypad_pin_enable_ff == '0 |-> !set_req)
      else $error("request from disabled pins");
   // Edge-only mode ignores low levels
   a_edge_mode_only: assert property (@(posedge pclk) disable iff (!presetn)
      !mode_ff |-> !level_req)
      else $error("level request in edge mode");
   // Unmasked latch raises the request
   a_unmasked_irq: assert property (@(posedge pclk) disable iff (!presetn)
      latch_ff && !keypad_irq_mask_ff |-> keypad_irq)
      else $error("unmasked request missing");
   // Pending latch kept until a legal acknowledge
   a_latch_holds: assert property (@(posedge pclk) disable iff (!presetn)
      latch_ff && !ack_ok |=> latch_ff)
      else $error("pending latch lost");
   // No wake while the processor runs
   a_awake_no_wake: assert property (@(posedge pclk) disable iff (!presetn)
      !low_power_mode |-> !wake_request)
      else $error("wake while running");
   // Wake only from a pending request
   a_wake_needs_latch: assert property (@(posedge pclk) disable iff (!presetn)
      wake_request |-> latch_ff)
      else $error("wake without request");
   // Key request records its event
   a_key_status: assert property (@(posedge pclk) disable iff (!presetn)
      set_req |=> ev_status_ff[KPI_EV_KEY])
      else $error("key event not recorded");
   // Wake records its event
   a_wake_status: assert property (@(posedge pclk) disable iff (!presetn)
      wake_request |=> ev_status_ff[KPI_EV_WAKE])
      else $error("wake event not recorded");
   // Key event sticky until written one
   a_status_sticky: assert property (@(posedge pclk) disable iff (!presetn)
      ev_status_ff[KPI_EV_KEY] && !(cfg_wr && sel_ev_status && pwdata[KPI_EV_KEY]) |=> ev_status_ff[KPI_EV_KEY])
      else $error("key event lost");
   // Written one clears key event
   a_status_clear: assert property (@(posedge pclk) disable iff (!presetn)
      cfg_wr && sel_ev_status && pwdata[KPI_EV_KEY] && !set_req |=> !ev_status_ff[KPI_EV_KEY])
      else $error("key event not cleared");
   // Enabled key event drives the interrupt
   a_irq_enabled: assert property (@(posedge pclk) disable iff (!presetn)
      ev_status_ff[KPI_EV_KEY] && ev_mask_ff[KPI_EV_KEY] |-> irq)
      else $error("interrupt missing");
   // All events masked keeps interrupt low
   a_irq_needs_mask: assert property (@(posedge pclk) disable iff (!presetn)
      ev_mask_ff == KPI_EV_RESET |-> !irq)
      else $error("masked interrupt raised");
   // Pin level read shows synced pins
   a_pin_level_read: assert property (@(posedge pclk) disable iff (!presetn)
      setup_rd && sel_level |=> prdata[PINS-1:0] == $past(pins_s))
      else $error("pin level read mismatch");
   // Unmapped read returns zero
   a_unmapped_read: assert property (@(posedge pclk) disable iff (!presetn)
      setup_rd && !mapped |=> prdata == '0)
      else $error("unmapped read nonzero");
   // Read data stands until next read setup
   a_read_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !setup_rd |=> $stable(prdata))
      else $error("read data changed");
   // Mode and mask read back
   a_mode_read: assert property (@(posedge pclk) disable iff (!presetn)
      setup_rd && sel_status |=> prdata[KPI_BIT_MODE] == $past(mode_ff) && prdata[KPI_BIT_MASK] == $past(keypad_irq_mask_ff))
      else $error("mode or mask read mismatch");
   // Pin enables read back
   a_enable_read: assert property (@(posedge pclk) disable iff (!presetn)
      setup_rd && sel_enable |=> prdata[PINS-1:0] == $past(keypad_pin_enable_ff))
      else $error("pin enable read mismatch");
   // Break clear permit reads back
   a_permit_read: assert property (@(posedge pclk) disable iff (!presetn)
      setup_rd && sel_permit |=> prdata[KPI_BIT_PERMIT] == $past(break_clear_permit_ff))
      else $error("permit read mismatch");
endmodule

//--- kpi_keypad_model.sv
`timescale 1ns/1ns
// Keypad switches on pulled-up pins; a closed key pulls its pin low
module kpi_keypad_model (
   input wire logic pclk,
   output logic [6:0] keys
);
   // All switches open from time zero, so pins sit high before enabling
   initial keys = 7'h7F;
   // Close one switch just after an edge
   task automatic press(input int idx);
      @(posedge pclk);
      keys[idx] <= 1'b0;
   endtask
   // Open every switch; pull-ups bring the pins back high
   task automatic release_all();
      @(posedge pclk);
      keys <= 7'h7F;
   endtask
endmodule

//--- keypad_interrupt_unit_tb.sv
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module keypad_interrupt_unit_tb;
   import kpi_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [3:0] pstrb = 4'hF;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, keypad_irq, wake_request, irq;
   logic break_state = 1'b0, low_power_mode = 1'b0;
   logic [6:0] keys;
   int failures = 0, checks = 0;
   kpi_top kpi_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .keypad_input_pins(keys), .break_state(break_state), .low_power_mode(low_power_mode),
      .keypad_irq(keypad_irq), .wake_request(wake_request), .irq(irq));
   kpi_keypad_model kpi_keypad_model_i (.pclk(pclk), .keys(keys));
   // Clock of 10 ns
   initial begin
      forever #5 pclk = ~pclk;
   end
   // One APB transfer; holds the request until pready is seen high
   task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= data;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] addr, input logic [31:0] data);
      apb(1'b1, addr, data);
   endtask
   task automatic rdchk(input logic [11:0] addr, input logic [31:0] exp);
      apb(1'b0, addr, 32'h0);
      `CHK(rd, exp)
   endtask
   // Let pin sync and register updates land
   task automatic settle();
      repeat (8) @(posedge pclk);
      #1;
   endtask
   // Reset values, fixed-zero bits, refused address
   task automatic t_regs();
      rdchk(KPI_OFF_STATUS_CONTROL, 32'h0);
      rdchk(KPI_OFF_IRQ_MASK, 32'h0);
      wr(KPI_OFF_STATUS_CONTROL, 32'hFF);
      rdchk(KPI_OFF_STATUS_CONTROL, 32'h03);
      wr(KPI_OFF_STATUS_CONTROL, 32'h0);
      pstrb <= 4'hE;
      wr(KPI_OFF_STATUS_CONTROL, 32'h02);
      pstrb <= 4'hF;
      rdchk(KPI_OFF_STATUS_CONTROL, 32'h0);
      rdchk(KPI_OFF_PIN_LEVEL, 32'h7F);
      apb(1'b0, 12'hFF0, 32'h0);
      `CHK(err, 1'b1)
   endtask
   // Falling edge sets latch, request, status interrupt; ack clears
   task automatic t_edge();
      wr(KPI_OFF_PIN_ENABLE, 32'h7F);
      wr(KPI_OFF_IRQ_MASK, 32'h1);
      kpi_keypad_model_i.press(3);
      settle();
      `CHK(keypad_irq, 1'b1)
      `CHK(irq, 1'b1)
      rdchk(KPI_OFF_STATUS_CONTROL, 32'h08);
      kpi_keypad_model_i.release_all();
      wr(KPI_OFF_STATUS_CONTROL, 32'h04);
      settle();
      `CHK(keypad_irq, 1'b0)
      wr(KPI_OFF_IRQ_STATUS, 32'h3);
      settle();
      `CHK(irq, 1'b0)
   endtask
   // Mask holds request back; unmasked key wakes low power
   task automatic t_mask_wake();
      wr(KPI_OFF_STATUS_CONTROL, 32'h02);
      kpi_keypad_model_i.press(0);
      settle();
      `CHK(keypad_irq, 1'b0)
      rdchk(KPI_OFF_STATUS_CONTROL, 32'h0A);
      kpi_keypad_model_i.release_all();
      wr(KPI_OFF_STATUS_CONTROL, 32'h04);
      low_power_mode <= 1'b1;
      kpi_keypad_model_i.press(6);
      settle();
      `CHK(wake_request, 1'b1)
      rdchk(KPI_OFF_IRQ_STATUS, 32'h3);
      kpi_keypad_model_i.release_all();
      wr(KPI_OFF_STATUS_CONTROL, 32'h04);
      low_power_mode <= 1'b0;
   endtask
   // Break state: ack ignored without permit, works with it, stays clear
   task automatic t_break();
      kpi_keypad_model_i.press(1);
      settle();
      kpi_keypad_model_i.release_all();
      break_state <= 1'b1;
      wr(KPI_OFF_STATUS_CONTROL, 32'h04);
      settle();
      rdchk(KPI_OFF_STATUS_CONTROL, 32'h08);
      wr(KPI_OFF_BREAK_FLAG_CONTROL, 32'h1);
      wr(KPI_OFF_STATUS_CONTROL, 32'h04);
      settle();
      rdchk(KPI_OFF_STATUS_CONTROL, 32'h0);
      break_state <= 1'b0;
      settle();
      rdchk(KPI_OFF_STATUS_CONTROL, 32'h0);
      wr(KPI_OFF_BREAK_FLAG_CONTROL, 32'h0);
   endtask
   // Level mode re-latches while held; ack after pin recovers
   task automatic t_level();
      wr(KPI_OFF_STATUS_CONTROL, 32'h01);
      kpi_keypad_model_i.press(2);
      settle();
      wr(KPI_OFF_STATUS_CONTROL, 32'h05);
      settle();
      rdchk(KPI_OFF_STATUS_CONTROL, 32'h09);
      kpi_keypad_model_i.release_all();
      settle();
      wr(KPI_OFF_STATUS_CONTROL, 32'h05);
      settle();
      rdchk(KPI_OFF_STATUS_CONTROL, 32'h01);
   endtask
   // Verdict and end of run
   task automatic final_report();
      $display("checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_edge();
      t_mask_wake();
      t_break();
      t_level();
      final_report();
   end
   // Watchdog against a hang
   initial begin
      #100000;
      failures++;
      final_report();
   end
endmodule
